// ---- logic/srwp_defs.vh ----
/*
 * shared constants of the secured-region host controller: register map,
 * field positions, reset values, command words and flash bus timing.
 * assumes a 10 MHz system clock and a x16 flash data bus.
 */
`ifndef SRWP_DEFS_VH
`define SRWP_DEFS_VH

// register word offsets on the apb side
`define SRWP_REG_CTRL     8'h00
`define SRWP_REG_ADDR     8'h04
`define SRWP_REG_WDATA    8'h08
`define SRWP_REG_RDATA    8'h0C
`define SRWP_REG_STATUS   8'h10

// control register fields
`define SRWP_CTRL_GO      0
`define SRWP_CTRL_OP_LO   1
`define SRWP_CTRL_OP_HI   3
`define SRWP_CTRL_WP      4
`define SRWP_CTRL_FRST    5
`define SRWP_CTRL_RST_VAL 6'h10

// status register fields
`define SRWP_ST_BUSY      0
`define SRWP_ST_DONE      1
`define SRWP_ST_ERR       2
`define SRWP_ST_SECMODE   3
`define SRWP_ST_TOPBIT    4

// operation codes held in the control register
`define SRWP_OP_READ      3'h0
`define SRWP_OP_PROG      3'h1
`define SRWP_OP_ENTER     3'h2
`define SRWP_OP_EXIT      3'h3
`define SRWP_OP_RESET     3'h4

// flash command words and unlock addresses (x16 addressing)
`define SRWP_UNLK_A1      22'h00_0555
`define SRWP_UNLK_A2      22'h00_02AA
`define SRWP_UNLK_D1      16'h00AA
`define SRWP_UNLK_D2      16'h0055
`define SRWP_CMD_PROG     16'h00A0
`define SRWP_CMD_ENTER    16'h0088
`define SRWP_CMD_EXIT1    16'h0090
`define SRWP_CMD_EXIT2    16'h0000
`define SRWP_CMD_RESET    16'h00F0

// secured region spans 256 bytes, i.e. 128 words
`define SRWP_SEC_WORDS    22'h00_0080

// timing, in nanoseconds as given; poll limit in reads
`define SRWP_CLK_NS       100
`define SRWP_T_ACC_NS     110
`define SRWP_T_WP_NS      35
`define SRWP_POLL_MAX     1024

`endif

// ---- logic/srwp_cyc.v ----
/*
 * one flash bus cycle, read or write, on the chip, output and write
 * enables. assumes the caller waits for done before the next start and
 * that the data pins reach this clock only through the two-flop sync here.
 */
`timescale 1ns/10ps
module srwp_cyc #(
   parameter AW      = 22,
   parameter DW      = 16,
   parameter ACC_CYC = 2,
   parameter WP_CYC  = 1
) (
   // clock and reset
   input  wire          sys_clk,
   input  wire          sys_rst,
   // request from the sequencer
   input  wire          start,
   input  wire          is_write,
   input  wire [AW-1:0] addr,
   input  wire [DW-1:0] wdata,
   output reg           done_r,
   output reg  [DW-1:0] rdata_r,
   // flash pins
   output reg  [AW-1:0] fl_addr_r,
   output reg  [DW-1:0] fl_dq_o_r,
   output reg           fl_dq_oe_r,
   input  wire [DW-1:0] fl_dq_i,
   output reg           fl_ce_n_r,
   output reg           fl_oe_n_r,
   output reg           fl_we_n_r
);

   localparam C_IDLE  = 3'd0;
   localparam C_SETUP = 3'd1;
   localparam C_WLO   = 3'd2;
   localparam C_WHI   = 3'd3;
   localparam C_RD    = 3'd4;
   // read waits access time plus the two sync stages
   localparam [7:0] RD_LAST = ACC_CYC + 1;
   localparam [7:0] WP_LAST = WP_CYC - 1;

   reg [2:0]    st_r;      // cycle state
   reg [7:0]    cnt_r;     // cycles spent in the current state
   reg [DW-1:0] sync1_r;   // first sync stage, read only by sync2_r
   reg [DW-1:0] sync2_r;   // second sync stage

   // data pins cross into the clock domain through two flops
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         sync1_r <= {DW{1'b0}};
         sync2_r <= {DW{1'b0}};
      end else begin
         sync1_r <= fl_dq_i;
         sync2_r <= sync1_r;
      end
   end

   // cycle engine; idle leaves every enable high so nothing can write
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r       <= C_IDLE;
         cnt_r      <= 8'h00;
         done_r     <= 1'b0;
         rdata_r    <= {DW{1'b0}};
         fl_addr_r  <= {AW{1'b0}};
         fl_dq_o_r  <= {DW{1'b0}};
         fl_dq_oe_r <= 1'b0;
         fl_ce_n_r  <= 1'b1;
         fl_oe_n_r  <= 1'b1;
         fl_we_n_r  <= 1'b1;
      end else begin
         done_r <= 1'b0;
         case (st_r)
            C_IDLE: begin
               cnt_r <= 8'h00;
               if (start) begin
                  fl_addr_r <= addr;
                  fl_ce_n_r <= 1'b0;
                  if (is_write) begin
                     // output enable stays high before we falls
                     fl_dq_o_r  <= wdata;
                     fl_dq_oe_r <= 1'b1;
                     st_r       <= C_SETUP;
                  end else begin
                     fl_oe_n_r <= 1'b0;
                     st_r      <= C_RD;
                  end
               end
            end
            C_SETUP: begin
               fl_we_n_r <= 1'b0;
               st_r      <= C_WLO;
            end
            C_WLO: begin
               // command is latched on the rising edge of we
               if (cnt_r >= WP_LAST) begin
                  fl_we_n_r <= 1'b1;
                  cnt_r     <= 8'h00;
                  st_r      <= C_WHI;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            C_WHI: begin
               // data held one cycle past the we edge, then released
               fl_ce_n_r  <= 1'b1;
               fl_dq_oe_r <= 1'b0;
               done_r     <= 1'b1;
               st_r       <= C_IDLE;
            end
            C_RD: begin
               if (cnt_r >= RD_LAST) begin
                  rdata_r   <= sync2_r;
                  fl_oe_n_r <= 1'b1;
                  fl_ce_n_r <= 1'b1;
                  done_r    <= 1'b1;
                  st_r      <= C_IDLE;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            default: begin
               st_r <= C_IDLE;
            end
         endcase
      end
   end

endmodule

// ---- logic/srwp_host.v ----
/*
 * host controller for the secured one-time region and write guard of a
 * parallel nor flash. software drives it over apb; it issues the flash
 * command sequences and polls program completion. assumes the flash pins
 * are wired straight to the part and the data bus is resolved outside.
 */
`timescale 1ns/10ps
`include "srwp_defs.vh"
module srwp_host #(
   parameter AW       = 22,
   parameter DW       = 16,
   parameter POLL_MAX = `SRWP_POLL_MAX
) (
   // clock and reset
   input  wire          sys_clk,
   input  wire          sys_rst,
   // apb slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [7:0]    paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata_r,
   output reg           pready_r,
   output reg           pslverr_r,
   // flash pins
   output wire [AW-1:0] fl_addr,
   output wire [DW-1:0] fl_dq_o,
   output wire          fl_dq_oe,
   input  wire [DW-1:0] fl_dq_i,
   output wire          fl_ce_n,
   output wire          fl_oe_n,
   output wire          fl_we_n,
   output reg           write_guard_accel_pin,
   output reg           fl_rst_n_r
);

   // flash timing in clock cycles: access rounds up, pulse rounds up
   localparam ACC_CYC = (`SRWP_T_ACC_NS + `SRWP_CLK_NS - 1) / `SRWP_CLK_NS;
   localparam WP_CYC  = (`SRWP_T_WP_NS + `SRWP_CLK_NS - 1) / `SRWP_CLK_NS;
   localparam [15:0] POLL_LAST = POLL_MAX - 1;

   // sequencer states
   localparam M_IDLE  = 3'd0;
   localparam M_ISSUE = 3'd1;
   localparam M_WAIT  = 3'd2;
   localparam M_POLL  = 3'd3;
   localparam M_PWAIT = 3'd4;

   reg [2:0]    op_r;      // selected operation
   reg [AW-1:0] addr_r;    // target word address
   reg [DW-1:0] wdata_r;   // program data
   reg [DW-1:0] rdata_r;   // last data read from the flash
   reg          busy_r;    // sequence in flight
   reg          done_r;    // sticky, write one to clear
   reg          err_r;     // sticky, write one to clear
   reg          sec_r;     // region currently mapped in the flash
   reg [2:0]    mst_r;     // sequencer state
   reg [1:0]    step_r;    // index within the command sequence
   reg [15:0]   poll_r;    // poll reads issued so far
   reg          cyc_go_r;  // start pulse to the cycle engine
   reg          cyc_wr_r;  // engine cycle direction
   reg [AW-1:0] cyc_a_r;   // engine cycle address
   reg [DW-1:0] cyc_d_r;   // engine cycle data
   wire         cyc_done;  // engine finished a cycle
   wire [DW-1:0] cyc_rd;   // engine read data

   // apb handshake terms
   wire acc    = psel & penable & pready_r;
   wire wr_acc = acc & pwrite;
   wire mapped = (paddr == `SRWP_REG_CTRL) || (paddr == `SRWP_REG_ADDR) ||
                 (paddr == `SRWP_REG_WDATA) || (paddr == `SRWP_REG_RDATA) ||
                 (paddr == `SRWP_REG_STATUS);
   wire go     = wr_acc && (paddr == `SRWP_REG_CTRL) &&
                 pwdata[`SRWP_CTRL_GO] && !busy_r;

   // command word for a step of a sequence: {last, address, data}
   function [AW+DW:0] seq_word;
      input [2:0]    op;
      input [1:0]    step;
      input [AW-1:0] a;
      input [DW-1:0] d;
      begin
         seq_word = {1'b1, `SRWP_UNLK_A1, `SRWP_CMD_RESET};
         if (op == `SRWP_OP_READ) begin
            seq_word = {1'b1, a, d};
         end else if (op == `SRWP_OP_RESET) begin
            seq_word = {1'b1, `SRWP_UNLK_A1, `SRWP_CMD_RESET};
         end else if (step == 2'd0) begin
            seq_word = {1'b0, `SRWP_UNLK_A1, `SRWP_UNLK_D1};
         end else if (step == 2'd1) begin
            seq_word = {1'b0, `SRWP_UNLK_A2, `SRWP_UNLK_D2};
         end else if (step == 2'd2) begin
            if (op == `SRWP_OP_PROG) begin
               seq_word = {1'b0, `SRWP_UNLK_A1, `SRWP_CMD_PROG};
            end else if (op == `SRWP_OP_ENTER) begin
               seq_word = {1'b1, `SRWP_UNLK_A1, `SRWP_CMD_ENTER};
            end else begin
               seq_word = {1'b0, `SRWP_UNLK_A1, `SRWP_CMD_EXIT1};
            end
         end else if (op == `SRWP_OP_PROG) begin
            seq_word = {1'b1, a, d};
         end else begin
            seq_word = {1'b1, {AW{1'b0}}, `SRWP_CMD_EXIT2};
         end
      end
   endfunction

   wire [AW+DW:0] cur = seq_word(op_r, step_r, addr_r, wdata_r);
   wire           cur_last = cur[AW+DW];

   // array accesses outside the region while it is mapped are refused,
   // since they would land in the region instead of the array
   wire outside = sec_r && (addr_r >= `SRWP_SEC_WORDS) &&
                  ((op_r == `SRWP_OP_READ) || (op_r == `SRWP_OP_PROG));

   // apb slave: pready rises at the start of the first access cycle so access ends at once
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= psel & ~penable;
         pslverr_r <= psel & ~penable & ~mapped;
         prdata_r  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            if (paddr == `SRWP_REG_CTRL) begin
               prdata_r <= {26'h000_0000, ~fl_rst_n_r, write_guard_accel_pin,
                            op_r, 1'b0};
            end else if (paddr == `SRWP_REG_ADDR) begin
               prdata_r <= {{(32-AW){1'b0}}, addr_r};
            end else if (paddr == `SRWP_REG_WDATA) begin
               prdata_r <= {{(32-DW){1'b0}}, wdata_r};
            end else if (paddr == `SRWP_REG_RDATA) begin
               prdata_r <= {{(32-DW){1'b0}}, rdata_r};
            end else if (paddr == `SRWP_REG_STATUS) begin
               prdata_r <= {27'h000_0000, rdata_r[7], sec_r, err_r,
                            done_r, busy_r};
            end
         end
      end
   end

   // software-written control and data registers
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         op_r                  <= `SRWP_OP_READ;
         addr_r                <= {AW{1'b0}};
         wdata_r               <= {DW{1'b0}};
         write_guard_accel_pin <= 1'b1;
         fl_rst_n_r            <= 1'b1;
      end else if (wr_acc && !busy_r) begin
         // operands frozen while a sequence runs
         if (paddr == `SRWP_REG_CTRL) begin
            op_r <= pwdata[`SRWP_CTRL_OP_HI:`SRWP_CTRL_OP_LO];
            // low guard level blocks the boundary sector
            write_guard_accel_pin <= pwdata[`SRWP_CTRL_WP];
            fl_rst_n_r            <= ~pwdata[`SRWP_CTRL_FRST];
         end else if (paddr == `SRWP_REG_ADDR) begin
            addr_r <= pwdata[AW-1:0];
         end else if (paddr == `SRWP_REG_WDATA) begin
            wdata_r <= pwdata[DW-1:0];
         end
      end
   end

   // sequencer: walks a command sequence one bus cycle at a time
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         mst_r    <= M_IDLE;
         step_r   <= 2'd0;
         poll_r   <= 16'h0000;
         busy_r   <= 1'b0;
         done_r   <= 1'b0;
         err_r    <= 1'b0;
         sec_r    <= 1'b0;
         rdata_r  <= {DW{1'b0}};
         cyc_go_r <= 1'b0;
         cyc_wr_r <= 1'b0;
         cyc_a_r  <= {AW{1'b0}};
         cyc_d_r  <= {DW{1'b0}};
      end else begin
         cyc_go_r <= 1'b0;
         // software clears stickies; a set in the same cycle wins below
         if (wr_acc && (paddr == `SRWP_REG_STATUS)) begin
            if (pwdata[`SRWP_ST_DONE]) begin
               done_r <= 1'b0;
            end
            if (pwdata[`SRWP_ST_ERR]) begin
               err_r <= 1'b0;
            end
         end
         // hardware reset of the flash unmaps the region
         if (!fl_rst_n_r) begin
            sec_r <= 1'b0;
         end
         case (mst_r)
            M_IDLE: begin
               step_r <= 2'd0;
               poll_r <= 16'h0000;
               if (go) begin
                  busy_r <= 1'b1;
                  mst_r  <= M_ISSUE;
               end
            end
            M_ISSUE: begin
               if (outside) begin
                  // mapped region must be left first
                  err_r  <= 1'b1;
                  done_r <= 1'b1;
                  busy_r <= 1'b0;
                  mst_r  <= M_IDLE;
               end else begin
                  // unlock writes lead the command word for every operation but read and reset
                  cyc_go_r <= 1'b1;
                  cyc_wr_r <= (op_r != `SRWP_OP_READ);
                  cyc_a_r  <= cur[AW+DW-1:DW];
                  cyc_d_r  <= cur[DW-1:0];
                  mst_r    <= M_WAIT;
               end
            end
            M_WAIT: begin
               if (cyc_done) begin
                  if (!cur_last) begin
                     step_r <= step_r + 2'd1;
                     mst_r  <= M_ISSUE;
                  end else if (op_r == `SRWP_OP_PROG) begin
                     mst_r <= M_POLL;
                  end else begin
                     if (op_r == `SRWP_OP_READ) begin
                        rdata_r <= cyc_rd;
                     end
                     // three-cycle entry maps the region
                     if (op_r == `SRWP_OP_ENTER) begin
                        sec_r <= 1'b1;
                     end
                     if (op_r == `SRWP_OP_EXIT) begin
                        sec_r <= 1'b0;
                     end
                     done_r <= 1'b1;
                     busy_r <= 1'b0;
                     mst_r  <= M_IDLE;
                  end
               end
            end
            M_POLL: begin
               cyc_go_r <= 1'b1;
               cyc_wr_r <= 1'b0;
               cyc_a_r  <= addr_r;
               mst_r    <= M_PWAIT;
            end
            M_PWAIT: begin
               if (cyc_done) begin
                  rdata_r <= cyc_rd;
                  poll_r  <= poll_r + 16'h0001;
                  if (cyc_rd[7] == wdata_r[7]) begin
                     // true data back: any mismatch means protected
                     err_r  <= err_r | (cyc_rd != wdata_r);
                     done_r <= 1'b1;
                     busy_r <= 1'b0;
                     mst_r  <= M_IDLE;
                  end else if (poll_r >= POLL_LAST) begin
                     // bounded wait so a stuck part cannot hang the bus
                     err_r  <= 1'b1;
                     done_r <= 1'b1;
                     busy_r <= 1'b0;
                     mst_r  <= M_IDLE;
                  end else begin
                     mst_r <= M_POLL;
                  end
               end
            end
            default: begin
               mst_r <= M_IDLE;
            end
         endcase
      end
   end

   // single bus cycle engine; idle keeps every enable high
   srwp_cyc #(
      .AW      (AW),
      .DW      (DW),
      .ACC_CYC (ACC_CYC),
      .WP_CYC  (WP_CYC)
   ) u_cyc (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .start      (cyc_go_r),
      .is_write   (cyc_wr_r),
      .addr       (cyc_a_r),
      .wdata      (cyc_d_r),
      .done_r     (cyc_done),
      .rdata_r    (cyc_rd),
      .fl_addr_r  (fl_addr),
      .fl_dq_o_r  (fl_dq_o),
      .fl_dq_oe_r (fl_dq_oe),
      .fl_dq_i    (fl_dq_i),
      .fl_ce_n_r  (fl_ce_n),
      .fl_oe_n_r  (fl_oe_n),
      .fl_we_n_r  (fl_we_n)
   );

endmodule

// ---- tb/srwp_host_assertions.sv ----
/*
 * checker for the secured-region host: flash strobes and apb answers.
 * assumes it is bound to srwp_host and sees only that module's ports.
 */
`timescale 1ns/10ps
module srwp_host_assertions (
   // clock and reset
   input wire        sys_clk,
   input wire        sys_rst,
   // apb side
   input wire        psel,
   input wire        penable,
   input wire        pready_r,
   input wire        pslverr_r,
   // flash pins
   input wire [21:0] fl_addr,
   input wire [15:0] fl_dq_o,
   input wire        fl_dq_oe,
   input wire        fl_ce_n,
   input wire        fl_oe_n,
   input wire        fl_we_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // a write strobe only with the chip selected and its outputs off
   a_write_needs_ce: assert property (
      !fl_we_n |-> !fl_ce_n && fl_oe_n)
      else $error("write strobe without select");
   // reads never overlap a strobe or our own drive, avoiding contention
   a_read_no_drive: assert property (
      !fl_oe_n |-> fl_we_n && !fl_dq_oe)
      else $error("read overlaps write or drive");
   a_idle_after_rst: assert property ($fell(sys_rst) |->
      fl_ce_n && fl_we_n && fl_oe_n && !fl_dq_oe)
      else $error("flash pins not idle after reset");
   a_we_one_cycle: assert property ($fell(fl_we_n) |=> $rose(fl_we_n))
      else $error("write pulse not one cycle");
   a_write_data_held: assert property ($fell(fl_we_n) |=>
      fl_dq_oe && $stable(fl_dq_o) && $stable(fl_addr))
      else $error("write data moved under strobe");
   a_ce_spans_we: assert property ($rose(fl_we_n) |-> !fl_ce_n)
      else $error("select dropped before strobe end");
   a_read_four_clk: assert property ($fell(fl_oe_n) |->
      !fl_oe_n [*4] ##1 fl_oe_n)
      else $error("read strobe length wrong");
   a_ready_zero_ws: assert property (psel && !penable |=> pready_r)
      else $error("apb answer late");
   a_ready_single: assert property (pready_r |=> !pready_r)
      else $error("ready longer than one cycle");
   a_err_with_ready: assert property (pslverr_r |-> pready_r)
      else $error("error without ready");
endmodule
bind srwp_host srwp_host_assertions u_chk (
   .sys_clk   (sys_clk),
   .sys_rst   (sys_rst),
   .psel      (psel),
   .penable   (penable),
   .pready_r  (pready_r),
   .pslverr_r (pslverr_r),
   .fl_addr   (fl_addr),
   .fl_dq_o   (fl_dq_o),
   .fl_dq_oe  (fl_dq_oe),
   .fl_ce_n   (fl_ce_n),
   .fl_oe_n   (fl_oe_n),
   .fl_we_n   (fl_we_n)
);

// ---- tb/srwp_flash_model.sv ----
/*
 * behavioural flash: first sector, secured region, unlock decoding.
 * assumes the host drives the pins; data out is resolved by the bench.
 */
`timescale 1ns/10ps
`include "srwp_defs.vh"
module srwp_flash_model #(
   parameter LOCKED = 1'b0,     // indicator fixed per part
   parameter SERIAL = 16'hC3C3, // arbitrary serial pattern
   parameter FILL   = 16'h0000  // fixed value of first-sector words outside the mapped region
) (
   // flash pins
   input wire [21:0] fl_addr,
   input wire [15:0] fl_dq_o,
   input wire        fl_ce_n,
   input wire        fl_oe_n,
   input wire        fl_we_n,
   input wire        wp,
   input wire        fl_rst_n,
   input wire        supply_ok,
   output wire [15:0] fl_dq_i
);
   reg  [15:0] arr [0:255];  // first sector only, aliased above
   reg  [15:0] sec [0:127];  // 256-byte region
   reg  [2:0]  st;           // starts in read mode
   reg         mapped;       // region mapping
   reg  [15:0] last;         // last word shown on the bus
   wire        in_sec = mapped && fl_addr < `SRWP_SEC_WORDS;
   // rest of the first sector has no content while the region is mapped
   wire        in_gap = mapped && !in_sec && fl_addr < 22'h00_0100;
   wire [15:0] word   = in_sec ? sec[fl_addr[6:0]] :
                        in_gap ? FILL : arr[fl_addr[7:0]];
   integer     i;
   // released bus shows the inverse so stale data never matches
   assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? word : ~last;
   initial begin
      st = 3'd0;
      mapped = 1'b0;
      last = 16'h0000;
      for (i = 0; i < 256; i = i + 1) arr[i] = 16'hFFFF;
      for (i = 0; i < 128; i = i + 1) sec[i] = 16'hFFFF;
      if (LOCKED) for (i = 0; i < 8; i = i + 1) sec[i] = SERIAL;
   end
   always @(posedge fl_oe_n) last <= word;
   // commands only on a clean strobe edge after the unlock pair
   always @(posedge fl_we_n or negedge fl_rst_n) begin
      if (!fl_rst_n) begin
         st <= 3'd0;
         mapped <= 1'b0;
      end else if (!supply_ok) begin
         // below lockout every write is dropped, read mode resumes
         st <= 3'd0;
      end else if (!fl_ce_n && fl_oe_n) begin
         case (st)
            3'd0: st <= (fl_addr == `SRWP_UNLK_A1 &&
                         fl_dq_o == `SRWP_UNLK_D1) ? 3'd1 : 3'd0;
            3'd1: st <= (fl_addr == `SRWP_UNLK_A2 &&
                         fl_dq_o == `SRWP_UNLK_D2) ? 3'd2 : 3'd0;
            3'd2: begin
               st <= (fl_dq_o == `SRWP_CMD_PROG) ? 3'd3 :
                     (fl_dq_o == `SRWP_CMD_EXIT1) ? 3'd4 : 3'd0;
               if (fl_dq_o == `SRWP_CMD_ENTER) mapped <= 1'b1;
            end
            3'd3: begin
               st <= 3'd0;
               // locked region and guarded sector keep contents
               if (in_sec && !LOCKED)
                  sec[fl_addr[6:0]] <= word & fl_dq_o;
               else if (!in_sec && (wp || fl_addr > 22'h00_00FF))
                  arr[fl_addr[7:0]] <= word & fl_dq_o;
            end
            default: begin
               st <= 3'd0;
               if (fl_dq_o == `SRWP_CMD_EXIT2) mapped <= 1'b0;
            end
         endcase
      end
   end
endmodule

// ---- tb/srwp_host_bench.sv ----
/*
 * bench for srwp_host: apb tasks drive flash operations against a model.
 * assumes a 10 MHz clock and the host's zero-wait apb answer.
 */
`timescale 1ns/10ps
`include "srwp_defs.vh"
module srwp_host_bench;
   reg         sys_clk = 1'b0;
   reg         sys_rst = 1'b1;
   reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h0000_0000;
   wire [31:0] prdata_r;
   wire        pready_r, pslverr_r;
   wire [21:0] fl_addr;
   wire [15:0] fl_dq_o, fl_dq_i;
   wire        fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, wg, fl_rst_n_r;
   reg  [31:0] rd;
   reg         serr;
   reg         guard = 1'b1;  // guard level written with each go
   reg         supply_ok = 1'b1; // flash supply above lockout
   integer     err_count = 0, num_checks = 0;
   srwp_host #(.POLL_MAX(8)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
      .pslverr_r(pslverr_r), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
      .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n),
      .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
      .write_guard_accel_pin(wg), .fl_rst_n_r(fl_rst_n_r));
   srwp_flash_model flash (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
      .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .wp(wg),
      .fl_rst_n(fl_rst_n_r), .supply_ok(supply_ok), .fl_dq_i(fl_dq_i));
   initial forever #50 sys_clk = ~sys_clk;
   // compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // one apb transfer, held until ready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      begin
         @(posedge sys_clk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= wd;
         @(posedge sys_clk);
         penable <= 1'b1;
         // only the watchdog ends a wait for the answer
         do begin
            @(posedge sys_clk);
         end while (pready_r !== 1'b1);
         rd = prdata_r;
         serr = pslverr_r;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // run one flash operation, check status flags, clear them
   task op(input logic [2:0] c, input logic [21:0] a, input logic [15:0] d,
           input logic e, input logic m);
      integer n;
      begin
         apb(1'b1, `SRWP_REG_ADDR, {10'h000, a});
         apb(1'b1, `SRWP_REG_WDATA, {16'h0000, d});
         apb(1'b1, `SRWP_REG_CTRL, {27'h0, guard, c, 1'b1});
         n = 0;
         do begin
            apb(1'b0, `SRWP_REG_STATUS, 32'h0);
            n = n + 1;
         end while (rd[0] !== 1'b0 && n < 200);
         chk(rd[3:0], {28'h0, m, e, 2'b10});
         apb(1'b1, `SRWP_REG_STATUS, 32'h0000_0006);
      end
   endtask
   task rdchk(input logic [15:0] exp);
      begin
         apb(1'b0, `SRWP_REG_RDATA, 32'h0);
         chk(rd[15:0], exp);
      end
   endtask
   task results;
      begin
         $display("errors %0d checks %0d", err_count, num_checks);
         if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // hang guard, well past the several hundred cycles the tests need
   initial begin
      repeat (30000) @(posedge sys_clk);
      err_count = err_count + 1;
      results;
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      apb(1'b0, `SRWP_REG_CTRL, 32'h0);
      chk(rd, 32'h0000_0010);
      apb(1'b0, `SRWP_REG_STATUS, 32'h0);
      chk(rd[3:0], 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, serr}, 32'h1);
      op(`SRWP_OP_PROG, 22'h5, 16'h1234, 1'b0, 1'b0);
      op(`SRWP_OP_READ, 22'h5, 16'h0, 1'b0, 1'b0);
      rdchk(16'h1234);
      op(`SRWP_OP_ENTER, 22'h0, 16'h0, 1'b0, 1'b1);
      op(`SRWP_OP_READ, 22'h5, 16'h0, 1'b0, 1'b1);
      rdchk(16'hFFFF);
      op(`SRWP_OP_PROG, 22'h3, 16'h00AB, 1'b0, 1'b1);
      op(`SRWP_OP_READ, 22'h3, 16'h0, 1'b0, 1'b1);
      rdchk(16'h00AB);
      op(`SRWP_OP_READ, 22'h90, 16'h0, 1'b1, 1'b1);
      op(`SRWP_OP_EXIT, 22'h0, 16'h0, 1'b0, 1'b0);
      op(`SRWP_OP_READ, 22'h5, 16'h0, 1'b0, 1'b0);
      rdchk(16'h1234);
      guard = 1'b0;
      op(`SRWP_OP_PROG, 22'h6, 16'h0000, 1'b1, 1'b0);
      op(`SRWP_OP_READ, 22'h6, 16'h0, 1'b0, 1'b0);
      rdchk(16'hFFFF);
      guard = 1'b1;
      op(`SRWP_OP_PROG, 22'h6, 16'h0F0F, 1'b0, 1'b0);
      op(`SRWP_OP_READ, 22'h6, 16'h0, 1'b0, 1'b0);
      rdchk(16'h0F0F);
      supply_ok <= 1'b0;
      op(`SRWP_OP_PROG, 22'h7, 16'h0000, 1'b1, 1'b0);
      supply_ok <= 1'b1;
      op(`SRWP_OP_READ, 22'h7, 16'h0, 1'b0, 1'b0);
      rdchk(16'hFFFF);
      op(`SRWP_OP_ENTER, 22'h0, 16'h0, 1'b0, 1'b1);
      apb(1'b1, `SRWP_REG_CTRL, 32'h0000_0030);
      apb(1'b1, `SRWP_REG_CTRL, 32'h0000_0010);
      apb(1'b0, `SRWP_REG_STATUS, 32'h0);
      chk({31'h0, rd[3]}, 32'h0);
      op(`SRWP_OP_RESET, 22'h0, 16'h0, 1'b0, 1'b0);
      op(`SRWP_OP_READ, 22'h5, 16'h0, 1'b0, 1'b0);
      rdchk(16'h1234);
      results;
   end
endmodule
